/* rtl/mid_dispatch.sv */
// Interrupt dispatch top: request sampling, enables, priority and call sequencing.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module mid_dispatch (
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire mid_pkg::mid_axi_req_t bus_req,
   output var  mid_pkg::mid_axi_rsp_t bus_rsp,
   input  wire logic                  ext_irq_pin0_n,
   input  wire logic                  ext_irq_pin1_n,
   input  wire logic                  tmr0_overflow_flag,
   input  wire logic                  tmr1_overflow_flag,
   input  wire logic                  serial0_flag,
   input  wire logic                  tmr2_low_overflow_flag,
   input  wire logic                  tmr2_high_overflow_flag,
   input  wire logic                  spi_flag,
   input  wire logic                  instr_done,
   input  wire logic                  instr_is_return_from_irq_instr,
   output logic                       call_busy,
   output logic                       isr_start,
   output logic [15:0]                isr_vector,
   output logic [6:0]                 src_ack
);
   import mid_pkg::*;

   typedef struct packed {
      logic [2:0]         pin0_sync;
      logic [2:0]         pin1_sync;
      logic [1:0]         pin_lvl;
      logic [7:0]         en;
      logic [6:0]         prio;
      logic               win_v;
      logic [2:0]         win_idx;
      logic               win_hi;
      mid_state_t         st;
      logic [2:0]         cnt;
      logic [2:0]         cur_idx;
      logic               cur_hi;
      logic               act_lo;
      logic               act_hi;
      logic               after_return_from_irq_instr;
      logic               busy;
      logic               start;
      logic [15:0]        vec;
      logic [NUM_SRC-1:0] ack;
   } mid_core_t;

   mid_core_t          r;
   mid_core_t          next_r;
   mid_wr_t            wr;
   mid_sel_t           sel;
   logic [NUM_SRC-1:0] pend;
   logic [NUM_SRC-1:0] req;
   logic [NUM_SRC-1:0] elig;
   logic [31:0]        stat;
   logic               go;

   mid_axil_slave u_slave (
      .core_clk (core_clk),
      .rst      (rst),
      .bus_req  (bus_req),
      .bus_rsp  (bus_rsp),
      .wr       (wr),
      .en_val   (r.en),
      .prio_val (r.prio),
      .stat_val (stat)
   );

   mid_prio_sel u_sel (
      .req     (elig),
      .hi_mask (r.prio),
      .sel     (sel)
   );

   // Flags are passed in whatever the enable state; masking happens below.
   always_comb begin
      pend = {spi_flag,
              tmr2_low_overflow_flag | tmr2_high_overflow_flag,
              serial0_flag,
              tmr1_overflow_flag,
              r.pin_lvl[1],
              tmr0_overflow_flag,
              r.pin_lvl[0]};
   end

   // Bit i of the enable register masks source i; bit 7 masks all.
   always_comb begin
      req = pend & r.en[NUM_SRC-1:0]
            & {NUM_SRC{r.en[GLOBAL_EN_BIT]}};
   end

   // An active high routine shuts everyone out; an active low one
   // leaves room only for high priority sources.
   always_comb begin
      if (r.act_hi) begin
         elig = '0;
      end else if (r.act_lo) begin
         elig = req & r.prio;
      end else begin
         elig = req;
      end
   end

   // The registered winner lags one cycle, so the live selection must
   // agree with it; this keeps a stale winner from firing right after
   // an active level was pushed.
   always_comb begin
      go = (r.st == ST_IDLE) && instr_done && !instr_is_return_from_irq_instr
           && r.win_v && sel.v && (sel.idx == r.win_idx);
   end

   always_comb begin
      stat        = 32'h00000000;
      stat[14:8]  = pend;
      stat[6:4]   = r.cur_idx;
      stat[2]     = r.after_return_from_irq_instr;
      stat[1]     = r.act_hi;
      stat[0]     = r.act_lo;
   end

   always_comb begin
      next_r       = r;
      next_r.start = 1'b0;
      next_r.ack   = '0;

      // A pin level counts only once the last two stages agree.
      next_r.pin0_sync = {r.pin0_sync[1:0], ext_irq_pin0_n};
      next_r.pin1_sync = {r.pin1_sync[1:0], ext_irq_pin1_n};
      if (r.pin0_sync[2] == r.pin0_sync[1]) begin
         next_r.pin_lvl[0] = ~r.pin0_sync[2];
      end
      if (r.pin1_sync[2] == r.pin1_sync[1]) begin
         next_r.pin_lvl[1] = ~r.pin1_sync[2];
      end

      if (wr.en && (wr.addr == REG_EN_OFF)) begin
         next_r.en = wr.data;
      end
      if (wr.en && (wr.addr == REG_PRIO_OFF)) begin
         next_r.prio = wr.data[6:0];
      end

      // Detection stage: decode this cycle's requests every cycle.
      next_r.win_v   = sel.v;
      next_r.win_idx = sel.idx;
      next_r.win_hi  = sel.hi;

      case (r.st)
         ST_IDLE: begin
            if (instr_done && instr_is_return_from_irq_instr) begin
               // Pop the innermost level; a flag still set will be
               // decoded again and dispatched after one instruction.
               if (r.act_hi) begin
                  next_r.act_hi = 1'b0;
               end else begin
                  next_r.act_lo = 1'b0;
               end
               next_r.after_return_from_irq_instr = 1'b1;
            end else if (instr_done) begin
               next_r.after_return_from_irq_instr = 1'b0;
            end
            if (go) begin
               // The dispatch boundary is the first of the four call cycles.
               next_r.st      = ST_CALL;
               next_r.cnt     = CNT_START;
               next_r.busy    = 1'b1;
               next_r.cur_idx = r.win_idx;
               next_r.cur_hi  = r.win_hi;
            end
         end
         ST_CALL: begin
            // The core is locked in the call; boundaries are not expected.
            if (r.cnt == 3'(LONG_CALL_INSTR_CYCLES - 1)) begin
               next_r.st    = ST_IDLE;
               next_r.busy  = 1'b0;
               next_r.start = 1'b1;
               next_r.vec   = VEC_BASE
                              + 16'({r.cur_idx, 3'h0});
               next_r.ack[r.cur_idx] = 1'b1;
               if (r.cur_hi) begin
                  next_r.act_hi = 1'b1;
               end else begin
                  next_r.act_lo = 1'b1;
               end
            end else begin
               next_r.cnt = r.cnt + 3'h1;
            end
         end
         default: begin
            next_r.st   = ST_IDLE;
            next_r.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         r           <= '0;
         r.pin0_sync <= 3'h7;
         r.pin1_sync <= 3'h7;
         r.en        <= EN_RESET;
         r.prio      <= PRIO_RESET;
         r.st        <= ST_IDLE;
         r.vec       <= RESET_VEC;
      end else begin
         r <= next_r;
      end
   end

   assign call_busy  = r.busy;
   assign isr_start  = r.start;
   assign isr_vector = r.vec;
   assign src_ack    = r.ack;

   // Helper for the ordering check: requests of the winning level
   // that sit below the chosen index.
   logic [NUM_SRC-1:0] lvl_set;
   logic [NUM_SRC-1:0] below;
   always_comb begin
      lvl_set = sel.hi ? (elig & r.prio) : elig;
      below   = lvl_set & ((7'h01 << sel.idx) - 7'h01);
   end

   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence s_go;
      go;
   endsequence

   sequence s_call;
      call_busy [*3] ##1 (isr_start && !call_busy);
   endsequence

   AST_LONG_CALL_INSTR_LEN: assert property (s_go |=> s_call)
      else $error("call did not take four cycles");

   AST_VECTOR: assert property (s_go |-> ##4
      (isr_vector == VEC_BASE + 16'({$past(r.win_idx, 4), 3'h0})))
      else $error("vector does not match the dispatched source");

   AST_GLOBAL_OFF: assert property (!r.en[GLOBAL_EN_BIT] |=> !r.win_v)
      else $error("request decoded with global enable clear");

   // Checked on the live decode so that the enable and the index are of one cycle.
   AST_SRC_MASK: assert property (sel.v |-> r.en[sel.idx] && r.en[GLOBAL_EN_BIT])
      else $error("disabled source won decoding");

   AST_RETURN_FROM_IRQ_INSTR_GAP: assert property ((instr_done && instr_is_return_from_irq_instr && r.st == ST_IDLE)
      |-> !go ##1 r.after_return_from_irq_instr)
      else $error("call issued on the return boundary");

   AST_HI_NOPRE: assert property (go |-> !r.act_hi)
      else $error("high priority routine preempted");

   AST_EQ_BLOCK: assert property (go && !r.win_hi |-> !r.act_lo)
      else $error("low request dispatched over active low routine");

   AST_TIE_ORDER: assert property (sel.v |-> (below == '0) && lvl_set[sel.idx])
      else $error("tie not resolved to lowest index");

   AST_ACK_PUSH: assert property (isr_start |-> (r.act_lo || r.act_hi)
      && $onehot(src_ack))
      else $error("service start without active level or ack");

   sequence s_return_from_irq_instr_edge;
      instr_done && instr_is_return_from_irq_instr && (r.st == ST_IDLE);
   endsequence

   // The detection register must follow the live decode in every cycle.
   AST_DETECT: assert property (r.win_v == $past(sel.v))
      else $error("detection stage skipped a cycle");

   AST_START_PULSE: assert property (isr_start |=> !isr_start)
      else $error("service start lasted more than one cycle");

   // A return boundary never opens a call in the following cycle.
   AST_RETURN_FROM_IRQ_INSTR_QUIET: assert property (s_return_from_irq_instr_edge |=> !call_busy)
      else $error("call began right after a return boundary");

   AST_LO_SHUT: assert property (r.act_lo |-> ((elig & ~r.prio) == '0))
      else $error("low request eligible under an active routine");

   AST_HI_FIRST: assert property (sel.v && ((elig & r.prio) != '0)
      |-> r.prio[sel.idx])
      else $error("low source chosen over a high one");

   AST_EN_WRITE: assert property (wr.en && (wr.addr == REG_EN_OFF)
      |=> r.en == $past(wr.data))
      else $error("enable register write lost");

   // A pin level may only move once the last two stages agree.
   AST_PIN0_SYNC: assert property ($changed(r.pin_lvl[0])
      |-> $past(r.pin0_sync[2] == r.pin0_sync[1]))
      else $error("pin 0 level moved before the synchroniser settled");

   AST_PIN1_SYNC: assert property ($changed(r.pin_lvl[1])
      |-> $past(r.pin1_sync[2] == r.pin1_sync[1]))
      else $error("pin 1 level moved before the synchroniser settled");

   // The vector must stand unchanged between dispatches; it is not in any register that software can read.
   AST_VEC_HOLD: assert property (!isr_start |-> $stable(isr_vector))
      else $error("vector changed without a dispatch");

   AST_ACK_IDX: assert property (isr_start |-> src_ack[r.cur_idx])
      else $error("acknowledge does not name the dispatched source");
endmodule : mid_dispatch
`default_nettype wire

/* rtl/mid_pkg.sv */
// Constants, bus carriers and state codes for the interrupt dispatch block.
package mid_pkg;
   localparam int          NUM_SRC       = 7;
   localparam int          GLOBAL_EN_BIT = 7;
   localparam logic [7:0]  REG_EN_OFF    = 8'ha8;
   localparam logic [7:0]  REG_PRIO_OFF  = 8'hb8;
   localparam logic [7:0]  REG_STAT_OFF  = 8'hbc;
   localparam logic [7:0]  EN_RESET      = 8'h00;
   localparam logic [6:0]  PRIO_RESET    = 7'h00;
   localparam logic [15:0] RESET_VEC     = 16'h0000;
   localparam logic [15:0] VEC_BASE      = 16'h0003;
   localparam int          VEC_SHIFT     = 3;
   localparam int          DETECT_CYCLES = 1;
   localparam int          LONG_CALL_INSTR_CYCLES  = 4;
   localparam int          RETURN_FROM_IRQ_INSTR_CYCLES   = 5;
   localparam int          DIV_CYCLES    = 8;
   localparam int          BEST_CYCLES   = DETECT_CYCLES + LONG_CALL_INSTR_CYCLES;
   localparam int          WORST_CYCLES  = BEST_CYCLES + RETURN_FROM_IRQ_INSTR_CYCLES + DIV_CYCLES;
   localparam logic [2:0]  CNT_START     = 3'h1;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } mid_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } mid_axi_rsp_t;

   typedef struct packed {
      logic       en;
      logic [7:0] addr;
      logic [7:0] data;
   } mid_wr_t;

   typedef struct packed {
      logic       v;
      logic [2:0] idx;
      logic       hi;
   } mid_sel_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CALL = 2'b10
   } mid_state_t;
endpackage : mid_pkg

/* rtl/mid_prio_sel.sv */
// Two-level fixed-order priority selector over the eligible requests.
`timescale 1ns/1ns
`default_nettype none
module mid_prio_sel (
   input  wire logic [mid_pkg::NUM_SRC-1:0] req,
   input  wire logic [mid_pkg::NUM_SRC-1:0] hi_mask,
   output var  mid_pkg::mid_sel_t           sel
);
   import mid_pkg::*;

   logic [NUM_SRC-1:0] hi_req;
   logic [NUM_SRC-1:0] pick_set;

   always_comb begin
      hi_req   = req & hi_mask;
      pick_set = (hi_req != '0) ? hi_req : req;
      sel      = '0;
      sel.hi   = (hi_req != '0);
      // Walking downward lets the lowest index overwrite, so it wins ties.
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (pick_set[i]) begin
            sel.v   = 1'b1;
            sel.idx = 3'(i);
         end
      end
   end
endmodule : mid_prio_sel
`default_nettype wire

/* rtl/mid_axil_slave.sv */
// AXI4-Lite slave front end for the dispatch control registers.
`timescale 1ns/1ns
`default_nettype none
module mid_axil_slave (
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire mid_pkg::mid_axi_req_t bus_req,
   output var  mid_pkg::mid_axi_rsp_t bus_rsp,
   output var  mid_pkg::mid_wr_t      wr,
   input  wire logic [7:0]          en_val,
   input  wire logic [6:0]          prio_val,
   input  wire logic [31:0]         stat_val
);
   import mid_pkg::*;

   typedef struct packed {
      logic         aw_held;
      logic [7:0]   aw_addr;
      logic         w_held;
      logic [7:0]   w_data;
      logic         w_lane0;
      mid_axi_rsp_t rsp;
      mid_wr_t      wr;
   } mid_slv_t;

   mid_slv_t r;
   mid_slv_t next_r;
   logic     mapped;

   always_comb begin
      next_r       = r;
      next_r.wr.en = 1'b0;
      mapped       = (r.aw_addr == REG_EN_OFF) || (r.aw_addr == REG_PRIO_OFF)
                     || (r.aw_addr == REG_STAT_OFF);
      if (r.rsp.bvalid && bus_req.bready) begin
         next_r.rsp.bvalid = 1'b0;
      end
      if (bus_req.awvalid && r.rsp.awready) begin
         next_r.aw_held     = 1'b1;
         next_r.aw_addr     = bus_req.awaddr;
         next_r.rsp.awready = 1'b0;
      end
      if (bus_req.wvalid && r.rsp.wready) begin
         next_r.w_held     = 1'b1;
         next_r.w_data     = bus_req.wdata[7:0];
         next_r.w_lane0    = bus_req.wstrb[0];
         next_r.rsp.wready = 1'b0;
      end
      // Address and data may arrive in either order; commit once both are held.
      if (r.aw_held && r.w_held && !r.rsp.bvalid) begin
         next_r.aw_held     = 1'b0;
         next_r.w_held      = 1'b0;
         next_r.rsp.awready = 1'b1;
         next_r.rsp.wready  = 1'b1;
         next_r.rsp.bvalid  = 1'b1;
         next_r.rsp.bresp   = mapped ? RESP_OKAY : RESP_SLVERR;
         next_r.wr.en       = mapped && r.w_lane0;
         next_r.wr.addr     = r.aw_addr;
         next_r.wr.data     = r.w_data;
      end
      if (r.rsp.rvalid && bus_req.rready) begin
         next_r.rsp.rvalid  = 1'b0;
         next_r.rsp.arready = 1'b1;
      end
      if (bus_req.arvalid && r.rsp.arready) begin
         next_r.rsp.arready = 1'b0;
         next_r.rsp.rvalid  = 1'b1;
         next_r.rsp.rresp   = RESP_OKAY;
         case (bus_req.araddr)
            REG_EN_OFF:   next_r.rsp.rdata = {24'h000000, en_val};
            REG_PRIO_OFF: next_r.rsp.rdata = {24'h000000, 1'b1, prio_val};
            REG_STAT_OFF: next_r.rsp.rdata = stat_val;
            default: begin
               next_r.rsp.rdata = 32'h00000000;
               next_r.rsp.rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         r             <= '0;
         r.rsp.awready <= 1'b1;
         r.rsp.wready  <= 1'b1;
         r.rsp.arready <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign bus_rsp = r.rsp;
   assign wr      = r.wr;
endmodule : mid_axil_slave
`default_nettype wire

/* bench/mid_cpu_model.sv */
// Far-side model: instruction sequencer and peripheral pending flags.
`timescale 1ns/1ns
`default_nettype none
module mid_cpu_model import mid_pkg::*; (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [7:0] raise,
   input  wire logic [7:0] clr,
   input  wire logic       run_return_from_irq_instr,
   input  wire logic       call_busy,
   input  wire logic [6:0] src_ack,
   output logic            instr_done,
   output logic            instr_is_return_from_irq_instr,
   output logic [7:0]      flag
);
   logic [7:0] pend;
   int         cnt;

   // Sources 0 to 3 drop on dispatch; the others stay until software clears them.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pend <= 8'h00;
         cnt  <= 0;
      end else begin
         pend <= (pend | raise) & ~clr & ~{4'h0, src_ack[3:0]};
         if (run_return_from_irq_instr) begin
            cnt <= RETURN_FROM_IRQ_INSTR_CYCLES + DIV_CYCLES;
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
         end
      end
   end

   // A return is followed by a division, the slowest instruction, to stretch latency.
   always_comb begin
      instr_is_return_from_irq_instr = (cnt == DIV_CYCLES + 1);
      instr_done    = (cnt <= 1 || instr_is_return_from_irq_instr) && !call_busy;
   end

   assign flag = pend | raise;
endmodule : mid_cpu_model
`default_nettype wire

/* bench/tb_mid_dispatch.sv */
// Self-checking bench for the interrupt dispatch block.
`timescale 1ns/1ns
`default_nettype none
module tb_mid_dispatch;
   import mid_pkg::*;
   typedef struct {logic [7:0] en; logic [7:0] pr; logic [7:0] m; int idx; bit exact;} mid_row_t;
   logic         core_clk;
   logic         rst;
   mid_axi_req_t req;
   mid_axi_rsp_t rsp;
   logic [7:0]   raise;
   logic [7:0]   clr;
   logic [7:0]   flag;
   logic         run_return_from_irq_instr;
   logic         instr_done;
   logic         instr_is_return_from_irq_instr;
   logic         call_busy;
   logic         isr_start;
   logic [15:0]  isr_vector;
   logic [6:0]   src_ack;
   logic [15:0]  vec;
   logic [6:0]   ack;
   int           lat;
   int           nb;
   int           n_errors;
   int           n_tests;
   mid_row_t     rows [14] = '{
      '{8'h82, 8'h00, 8'h02, 1, 1},
      '{8'hfd, 8'h00, 8'h02, -1, 0},
      '{8'hff, 8'h00, 8'h0a, 1, 1},
      '{8'hff, 8'h08, 8'h0a, 3, 1},
      '{8'h7f, 8'h00, 8'h02, -1, 0},
      '{8'ha0, 8'h00, 8'h80, 5, 1},
      '{8'ha0, 8'h00, 8'h20, 5, 1},
      '{8'hdf, 8'h00, 8'h20, -1, 0},
      '{8'hc0, 8'h00, 8'h40, 6, 1},
      '{8'hbf, 8'h00, 8'h40, -1, 0},
      '{8'he6, 8'h00, 8'h19, -1, 0},
      '{8'h98, 8'h00, 8'h18, 3, 1},
      '{8'h81, 8'h00, 8'h01, 0, 0},
      '{8'h84, 8'h00, 8'h04, 2, 0}
   };

   mid_dispatch uut (.core_clk(core_clk), .rst(rst), .bus_req(req), .bus_rsp(rsp),
      .ext_irq_pin0_n(~flag[0]), .ext_irq_pin1_n(~flag[2]), .tmr0_overflow_flag(flag[1]),
      .tmr1_overflow_flag(flag[3]), .serial0_flag(flag[4]), .tmr2_low_overflow_flag(flag[5]),
      .tmr2_high_overflow_flag(flag[7]), .spi_flag(flag[6]), .instr_done(instr_done),
      .instr_is_return_from_irq_instr(instr_is_return_from_irq_instr), .call_busy(call_busy), .isr_start(isr_start),
      .isr_vector(isr_vector), .src_ack(src_ack));

   mid_cpu_model cpu (.core_clk(core_clk), .rst(rst), .raise(raise), .clr(clr),
      .run_return_from_irq_instr(run_return_from_irq_instr), .call_busy(call_busy), .src_ack(src_ack),
      .instr_done(instr_done), .instr_is_return_from_irq_instr(instr_is_return_from_irq_instr), .flag(flag));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic finish_test;
      if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic expire(input string n);
      chk(n, 1, 0);
      finish_test();
   endtask : expire

   task automatic chk_disp(input int i);
      chk("vector", VEC_BASE + (16'(i) << VEC_SHIFT), vec);
      chk("ack", 7'h01 << i, ack);
   endtask : chk_disp

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int k;
      bit aw;
      bit w;
      k = 0;
      aw = 1;
      w = 1;
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= {24'h000000, d};
      req.wstrb   <= 4'hf;
      req.bready  <= 1'b1;
      while ((aw || w) && k < 50) begin
         @(posedge core_clk);
         k++;
         if (aw && rsp.awready === 1'b1) begin
            aw = 0;
            req.awvalid <= 1'b0;
         end
         if (w && rsp.wready === 1'b1) begin
            w = 0;
            req.wvalid <= 1'b0;
         end
      end
      do begin
         @(posedge core_clk);
         k++;
      end while (rsp.bvalid !== 1'b1 && k < 100);
      req.bready <= 1'b0;
      if (k >= 100) expire("write");
      chk("bresp", er, rsp.bresp);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int k;
      k = 0;
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      do begin
         @(posedge core_clk);
         k++;
      end while (rsp.arready !== 1'b1 && k < 50);
      req.arvalid <= 1'b0;
      do begin
         @(posedge core_clk);
         k++;
      end while (rsp.rvalid !== 1'b1 && k < 100);
      req.rready <= 1'b0;
      if (k >= 100) expire("read");
      chk("rdata", e, rsp.rdata);
      chk("rresp", er, rsp.rresp);
   endtask : rchk

   // Latency counts from the cycle in which the flag first shows.
   task automatic wait_isr(input int lim, input logic [7:0] m, input logic [7:0] c,
                           input logic r);
      bit hit;
      bit seen;
      lat = 0;
      nb = 0;
      hit = 0;
      seen = 0;
      raise <= m;
      clr <= c;
      run_return_from_irq_instr <= r;
      while (!hit && lat < lim) begin
         @(posedge core_clk);
         if (lat == 0) begin
            raise <= 8'h00;
            clr <= 8'h00;
            run_return_from_irq_instr <= 1'b0;
         end
         lat++;
         hit = (isr_start === 1'b1);
         vec = isr_vector;
         ack = src_ack;
         if (!hit && seen && instr_done === 1'b1 && instr_is_return_from_irq_instr !== 1'b1) nb++;
         if (instr_done === 1'b1 && instr_is_return_from_irq_instr === 1'b1) seen = 1;
      end
      lat = hit ? lat - 1 : -1;
   endtask : wait_isr

   task automatic settle(input logic r);
      wait_isr(RETURN_FROM_IRQ_INSTR_CYCLES + DIV_CYCLES + 4, 8'h00, 8'hff, r);
      chk("quiet", 1, lat < 0);
   endtask : settle

   initial begin
      n_errors = 0;
      n_tests  = 0;
      rst      = 1'b1;
      req      = '0;
      raise    = 8'h00;
      clr      = 8'h00;
      run_return_from_irq_instr = 1'b0;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      foreach (rows[i]) begin
         wr(REG_EN_OFF, rows[i].en, RESP_OKAY);
         wr(REG_PRIO_OFF, rows[i].pr, RESP_OKAY);
         wait_isr(20, rows[i].m, 8'h00, 1'b0);
         if (rows[i].idx < 0) begin
            chk("masked", 1, lat < 0);
         end else begin
            chk_disp(rows[i].idx);
            if (rows[i].exact) chk("latency", BEST_CYCLES, lat);
         end
         settle(lat >= 0);
      end
      // Nesting: low blocked under low, high preempts low, high never preempted.
      wr(REG_EN_OFF, 8'hff, RESP_OKAY);
      wr(REG_PRIO_OFF, 8'h40, RESP_OKAY);
      wait_isr(20, 8'h02, 8'h00, 1'b0);
      chk_disp(1);
      wait_isr(20, 8'h08, 8'h00, 1'b0);
      chk("blocked", 1, lat < 0);
      wait_isr(20, 8'h40, 8'h00, 1'b0);
      chk_disp(6);
      wr(REG_PRIO_OFF, 8'h48, RESP_OKAY);
      wait_isr(20, 8'h00, 8'h00, 1'b0);
      chk("no preempt", 1, lat < 0);
      wait_isr(40, 8'h00, 8'h00, 1'b1);
      chk_disp(3);
      rchk(REG_PRIO_OFF, 32'h000000c8, RESP_OKAY);
      settle(1'b1);
      settle(1'b1);
      // A flag left set re-enters after one instruction following the return.
      wr(REG_EN_OFF, 8'h90, RESP_OKAY);
      wait_isr(20, 8'h10, 8'h00, 1'b0);
      chk_disp(4);
      wait_isr(40, 8'h00, 8'h00, 1'b1);
      chk_disp(4);
      chk("one instr", 1, nb);
      chk("worst", 1, lat > 0 && lat <= WORST_CYCLES);
      settle(1'b1);
      wr(8'hf0, 8'h11, RESP_SLVERR);
      rchk(8'hf0, 32'h00000000, RESP_SLVERR);
      rchk(REG_EN_OFF, 32'h00000090, RESP_OKAY);
      rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      chk("vector", RESET_VEC, isr_vector);
      rchk(REG_EN_OFF, {24'h000000, EN_RESET}, RESP_OKAY);
      rchk(REG_PRIO_OFF, {25'h0000001, PRIO_RESET}, RESP_OKAY);
      finish_test();
   end
endmodule : tb_mid_dispatch
`default_nettype wire
